/* hrb_pkg.sv */
// Constants, types and helpers shared by the health attribute record builder
package hrb_pkg;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_HZ          = 10_000_000;
	localparam int TEMP_PERIOD_S   = 4;
	localparam int TEMP_PERIOD_CYC = TEMP_PERIOD_S * CLK_HZ;

	// ----------------------------------------
	// Attribute identifiers
	// ----------------------------------------
	localparam logic [7:0] ID_ECC_CORR = 8'hcc;
	localparam logic [7:0] ID_UDMA_CRC = 8'hc7;
	localparam logic [7:0] ID_READS    = 8'he8;
	localparam logic [7:0] ID_POWER    = 8'h0c;
	localparam logic [7:0] ID_LBA_WR   = 8'hf1;
	localparam logic [7:0] ID_LBA_RD   = 8'hf2;
	localparam logic [7:0] ID_ANCHOR   = 8'hd6;
	localparam logic [7:0] ID_TRIM     = 8'hd7;
	localparam logic [7:0] ID_TEMP     = 8'hc2;

	// ----------------------------------------
	// Entry layout and fixed contents
	// ----------------------------------------
	localparam int          BYTE_ID     = 0;
	localparam int          BYTE_FLAG   = 1;
	localparam int          BYTE_VALUE  = 3;
	localparam int          BYTE_WORST  = 4;
	localparam int          BYTE_RAW    = 5;
	localparam int          RAW_BYTES   = 6;
	localparam int          BYTE_RSVD   = 11;
	localparam logic [15:0] FLAG_WORD   = 16'h0002;
	localparam logic [7:0]  FIXED_VALUE = 8'h64;
	localparam logic [7:0]  TRIM_MAX    = 8'h63;
	localparam logic [7:0]  RESET_BYTE  = 8'h00;

	// ----------------------------------------
	// Widths
	// ----------------------------------------
	localparam int CNT32_W   = 32;
	localparam int CNT48_W   = 48;
	localparam int LBA_TOT_W = 64;
	localparam int LBA_AMT_W = 16;
	localparam int LBA_SHIFT = 16;
	localparam int TEMP_W    = 8;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef logic [11:0][7:0] hrb_entry_t;

	typedef enum logic [3:0] {
		ATTR_ECC_CORR = 4'h0,
		ATTR_UDMA_CRC = 4'h1,
		ATTR_READS    = 4'h2,
		ATTR_POWER    = 4'h3,
		ATTR_LBA_WR   = 4'h4,
		ATTR_LBA_RD   = 4'h5,
		ATTR_ANCHOR   = 4'h6,
		ATTR_TRIM     = 4'h7,
		ATTR_TEMP     = 4'h8
	} hrb_attr_t;

	typedef struct packed {
		logic      valid;
		hrb_attr_t sel;
	} hrb_rd_req_t;

	typedef struct packed {
		logic                 valid;
		logic [LBA_AMT_W-1:0] count;
	} hrb_lba_evt_t;

	typedef struct packed {
		logic [CNT32_W-1:0]   power;
		logic [CNT32_W-1:0]   ecc_corr;
		logic [CNT32_W-1:0]   udma_crc;
		logic [CNT32_W-1:0]   anchor;
		logic [CNT48_W-1:0]   reads;
		logic [LBA_TOT_W-1:0] lba_wr;
		logic [LBA_TOT_W-1:0] lba_rd;
	} hrb_restore_t;

	// Assemble one entry, raw count least significant byte first
	function automatic hrb_entry_t hrb_make_entry(input logic [7:0] id,
			input logic [7:0] value, input logic [7:0] worst,
			input logic [CNT48_W-1:0] raw);
		hrb_entry_t e;
		e              = '0;
		e[BYTE_ID]     = id;
		e[BYTE_FLAG]   = FLAG_WORD[7:0];
		e[BYTE_FLAG+1] = FLAG_WORD[15:8];
		e[BYTE_VALUE]  = value;
		e[BYTE_WORST]  = worst;
		for (int i = 0; i < RAW_BYTES; i++) begin
			e[BYTE_RAW+i] = raw[8*i +: 8];
		end
		e[BYTE_RSVD]   = RESET_BYTE;
		return e;
	endfunction

endpackage

/* hrb_sat_counter.sv */
// Saturating event counter with preload
`timescale 1ns/1ns
module hrb_sat_counter #(
	parameter int W  = 32,
	parameter int AW = 1
) (
	// Clock and reset
	input  wire logic          core_clk,
	input  wire logic          arst_n,
	// Control
	input  wire logic          load,
	input  wire logic [W-1:0]  load_val,
	input  wire logic          inc,
	input  wire logic [AW-1:0] amt,
	// State
	output logic      [W-1:0]  count
);
	import hrb_pkg::*;

	function automatic logic [W-1:0] sat_add(input logic [W-1:0] a, input logic [AW-1:0] b);
		logic [W:0] s;
		s = {1'b0, a} + {{(W+1-AW){1'b0}}, b};
		return s[W] ? '1 : s[W-1:0];
	endfunction

	logic [AW-1:0] step;
	assign step = inc ? amt : '0;

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			count <= '0;
		end else if (load) begin
			count <= sat_add(load_val, step);
		end else if (inc) begin
			count <= sat_add(count, step);
		end
	end

endmodule

/* hrb_temp_tracker.sv */
// Periodic temperature sampling with min and max tracking
`timescale 1ns/1ns
module hrb_temp_tracker #(
	parameter int PERIOD_CYC = hrb_pkg::TEMP_PERIOD_CYC
) (
	// Clock and reset
	input  wire logic                       core_clk,
	input  wire logic                       arst_n,
	// Sensor handshake
	output logic                            temp_req,
	input  wire logic                       temp_ack,
	input  wire logic [hrb_pkg::TEMP_W-1:0] temp_data,
	// Tracked values
	output logic [hrb_pkg::TEMP_W-1:0]      cur,
	output logic [hrb_pkg::TEMP_W-1:0]      tmin,
	output logic [hrb_pkg::TEMP_W-1:0]      tmax
);
	import hrb_pkg::*;

	logic [31:0] tick_cnt;
	logic        have_sample;

	// Sample request every period
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			tick_cnt <= '0;
			temp_req <= 1'b0;
		end else begin
			temp_req <= (tick_cnt == 32'(PERIOD_CYC - 1));
			tick_cnt <= (tick_cnt == 32'(PERIOD_CYC - 1)) ? '0 : tick_cnt + 32'h1;
		end
	end

	// First sample seeds min and max
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			have_sample <= 1'b0;
			cur         <= '0;
			tmin        <= '0;
			tmax        <= '0;
		end else if (temp_ack) begin
			have_sample <= 1'b1;
			cur         <= temp_data;
			tmin        <= (!have_sample || temp_data < tmin) ? temp_data : tmin;
			tmax        <= (!have_sample || temp_data > tmax) ? temp_data : tmax;
		end
	end

	chk_temp_period: assert property (@(posedge core_clk) disable iff (!arst_n)
		temp_req |=> !temp_req [*8]) else $error("temperature request not periodic");

	chk_temp_order: assert property (@(posedge core_clk) disable iff (!arst_n)
		have_sample |-> (tmin <= cur && cur <= tmax)) else $error("min cur max out of order");

endmodule

/* hrb_attr_builder.sv */
// Health attribute record builder top
// What this block does
// - Correctable ECC entry uses id 204, raw holds correctable ECC count.
// - Correctable ECC count sits in raw bytes five to eight.
// - UDMA CRC entry uses id 199, count in bytes five to eight.
// - Read command entry uses id 232, six-byte count in bytes five-ten.
// - Power cycle entry uses id 12, counts power-ups in bytes five-eight.
// - Written data entry uses id 241, reports data in 32MB units.
// - Written entry bytes five-ten hold written blocks divided by 65536.
// - Read data entry uses id 242, bytes five-ten hold blocks read/65536.
// - Anchor entry uses id 214, counts every anchor rewrite of any cause.
// - Anchor rewrite count sits in raw bytes five to eight.
// - Trim entry uses id 215, value byte is trimmed capacity percent.
// - Trimmed percentage is clamped to 0 through 99.
// - Temperature entry uses id 194, value is current, worst is maximum.
// - Temperature bytes five, six, seven hold current, minimum, maximum.
// - Temperature is sampled every 4 s and entry refreshed per sample.
// - Every entry carries flag word 0002h in bytes one and two.
// - Value byte is fixed 64h except for trim and temperature.
// - Worst byte is fixed 64h except for trim and temperature.
`timescale 1ns/1ns
module hrb_attr_builder #(
	parameter int TEMP_PERIOD = hrb_pkg::TEMP_PERIOD_CYC
) (
	// Clock and reset
	input  wire logic                       core_clk,
	input  wire logic                       arst_n,
	// Event pulses from the flash core
	input  wire logic                       ecc_corr_evt,
	input  wire logic                       udma_crc_evt,
	input  wire logic                       flash_read_evt,
	input  wire logic                       anchor_rewrite_evt,
	input  wire hrb_pkg::hrb_lba_evt_t      lba_wr,
	input  wire hrb_pkg::hrb_lba_evt_t      lba_rd,
	// Restore of saved counts
	input  wire logic                       restore_valid,
	input  wire hrb_pkg::hrb_restore_t      restore,
	// Trim status
	input  wire logic                       trim_valid,
	input  wire logic [7:0]                 trim_pct,
	// Temperature sensor
	output logic                            temp_req,
	input  wire logic                       temp_ack,
	input  wire logic [hrb_pkg::TEMP_W-1:0] temp_data,
	// Entry read port
	input  wire hrb_pkg::hrb_rd_req_t       rd_req,
	output logic                            rd_ack,
	output hrb_pkg::hrb_attr_t              rd_sel,
	output hrb_pkg::hrb_entry_t             rd_entry
);
	import hrb_pkg::*;

	// ----------------------------------------
	// Counters
	// ----------------------------------------
	logic [CNT32_W-1:0]   cnt_ecc;
	logic [CNT32_W-1:0]   cnt_crc;
	logic [CNT32_W-1:0]   cnt_anchor;
	logic [CNT32_W-1:0]   cnt_power;
	logic [CNT48_W-1:0]   cnt_reads;
	logic [LBA_TOT_W-1:0] cnt_lba_wr;
	logic [LBA_TOT_W-1:0] cnt_lba_rd;
	logic                 booted;

	hrb_sat_counter #(.W(CNT32_W), .AW(1)) u_cnt_ecc (
		.core_clk (core_clk),
		.arst_n   (arst_n),
		.load     (restore_valid),
		.load_val (restore.ecc_corr),
		.inc      (ecc_corr_evt),
		.amt      (1'b1),
		.count    (cnt_ecc)
	);

	hrb_sat_counter #(.W(CNT32_W), .AW(1)) u_cnt_crc (
		.core_clk (core_clk),
		.arst_n   (arst_n),
		.load     (restore_valid),
		.load_val (restore.udma_crc),
		.inc      (udma_crc_evt),
		.amt      (1'b1),
		.count    (cnt_crc)
	);

	hrb_sat_counter #(.W(CNT48_W), .AW(1)) u_cnt_reads (
		.core_clk (core_clk),
		.arst_n   (arst_n),
		.load     (restore_valid),
		.load_val (restore.reads),
		.inc      (flash_read_evt),
		.amt      (1'b1),
		.count    (cnt_reads)
	);

	// anchor rewrites, repair and update alike
	hrb_sat_counter #(.W(CNT32_W), .AW(1)) u_cnt_anchor (
		.core_clk (core_clk),
		.arst_n   (arst_n),
		.load     (restore_valid),
		.load_val (restore.anchor),
		.inc      (anchor_rewrite_evt),
		.amt      (1'b1),
		.count    (cnt_anchor)
	);

	hrb_sat_counter #(.W(LBA_TOT_W), .AW(LBA_AMT_W)) u_cnt_lba_wr (
		.core_clk (core_clk),
		.arst_n   (arst_n),
		.load     (restore_valid),
		.load_val (restore.lba_wr),
		.inc      (lba_wr.valid),
		.amt      (lba_wr.count),
		.count    (cnt_lba_wr)
	);

	hrb_sat_counter #(.W(LBA_TOT_W), .AW(LBA_AMT_W)) u_cnt_lba_rd (
		.core_clk (core_clk),
		.arst_n   (arst_n),
		.load     (restore_valid),
		.load_val (restore.lba_rd),
		.inc      (lba_rd.valid),
		.amt      (lba_rd.count),
		.count    (cnt_lba_rd)
	);

	// ----------------------------------------
	// Power cycle count
	// ----------------------------------------
	// One increment in the first cycle after reset release
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			booted <= 1'b0;
		end else begin
			booted <= 1'b1;
		end
	end

	hrb_sat_counter #(.W(CNT32_W), .AW(1)) u_cnt_power (
		.core_clk (core_clk),
		.arst_n   (arst_n),
		.load     (restore_valid),
		.load_val (restore.power),
		.inc      (!booted),
		.amt      (1'b1),
		.count    (cnt_power)
	);

	// ----------------------------------------
	// Trim percentage
	// ----------------------------------------
	logic [7:0] trim_value;

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			trim_value <= '0;
		end else if (trim_valid) begin
			trim_value <= (trim_pct > TRIM_MAX) ? TRIM_MAX : trim_pct;
		end
	end

	// ----------------------------------------
	// Temperature
	// ----------------------------------------
	logic [TEMP_W-1:0] temp_cur;
	logic [TEMP_W-1:0] temp_min;
	logic [TEMP_W-1:0] temp_max;

	hrb_temp_tracker #(.PERIOD_CYC(TEMP_PERIOD)) u_temp (
		.core_clk  (core_clk),
		.arst_n    (arst_n),
		.temp_req  (temp_req),
		.temp_ack  (temp_ack),
		.temp_data (temp_data),
		.cur       (temp_cur),
		.tmin      (temp_min),
		.tmax      (temp_max)
	);

	// ----------------------------------------
	// Entry assembly
	// ----------------------------------------
	hrb_entry_t next_entry;

	always_comb begin
		next_entry = '0;
		unique case (rd_req.sel)
			// ECC count in bytes 5 to 8
			ATTR_ECC_CORR: next_entry = hrb_make_entry(ID_ECC_CORR, FIXED_VALUE,
					FIXED_VALUE, CNT48_W'(cnt_ecc));
			// CRC count in bytes 5 to 8
			ATTR_UDMA_CRC: next_entry = hrb_make_entry(ID_UDMA_CRC, FIXED_VALUE,
					FIXED_VALUE, CNT48_W'(cnt_crc));
			ATTR_READS:    next_entry = hrb_make_entry(ID_READS, FIXED_VALUE,
					FIXED_VALUE, cnt_reads);
			ATTR_POWER:    next_entry = hrb_make_entry(ID_POWER, FIXED_VALUE,
					FIXED_VALUE, CNT48_W'(cnt_power));
			// 32MB units, block total over 65536
			ATTR_LBA_WR:   next_entry = hrb_make_entry(ID_LBA_WR, FIXED_VALUE,
					FIXED_VALUE, cnt_lba_wr[LBA_TOT_W-1:LBA_SHIFT]);
			ATTR_LBA_RD:   next_entry = hrb_make_entry(ID_LBA_RD, FIXED_VALUE,
					FIXED_VALUE, cnt_lba_rd[LBA_TOT_W-1:LBA_SHIFT]);
			// anchor count in bytes 5 to 8
			ATTR_ANCHOR:   next_entry = hrb_make_entry(ID_ANCHOR, FIXED_VALUE,
					FIXED_VALUE, CNT48_W'(cnt_anchor));
			ATTR_TRIM:     next_entry = hrb_make_entry(ID_TRIM, trim_value,
					trim_value, '0);
			ATTR_TEMP:     next_entry = hrb_make_entry(ID_TEMP, temp_cur,
					temp_max, {24'h000000, temp_max, temp_min, temp_cur});
			default:       next_entry = '0;
		endcase
	end

	// ----------------------------------------
	// Read port
	// ----------------------------------------
	// Entry snapshot one cycle after the request
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			rd_ack   <= 1'b0;
			rd_sel   <= ATTR_ECC_CORR;
			rd_entry <= '0;
		end else begin
			rd_ack <= rd_req.valid;
			if (rd_req.valid) begin
				rd_sel   <= rd_req.sel;
				rd_entry <= next_entry;
			end
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	logic fixed_kind;
	logic legal_sel;
	assign legal_sel  = rd_sel <= ATTR_TEMP;
	assign fixed_kind = legal_sel && rd_sel != ATTR_TRIM && rd_sel != ATTR_TEMP;

	chk_ecc_entry: assert property (@(posedge core_clk) disable iff (!arst_n)
		rd_req.valid && rd_req.sel == ATTR_ECC_CORR |=> rd_ack && rd_entry[0] == 8'hcc
		&& rd_entry[8:5] == $past(cnt_ecc)) else $error("ecc entry wrong");

	chk_crc_entry: assert property (@(posedge core_clk) disable iff (!arst_n)
		rd_ack && rd_sel == ATTR_UDMA_CRC |-> rd_entry[0] == 8'hc7
		&& rd_entry[10:9] == 16'h0000) else $error("crc entry wrong");

	chk_power_once: assert property (@(posedge core_clk) disable iff (!arst_n)
		$rose(booted) && !$past(restore_valid) |-> cnt_power == 32'h1)
		else $error("power count not one after first power-up");

	chk_lba_div: assert property (@(posedge core_clk) disable iff (!arst_n)
		rd_req.valid && rd_req.sel == ATTR_LBA_WR |=>
		rd_entry[10:5] == $past(cnt_lba_wr[63:16])) else $error("written entry not divided");

	chk_flag_word: assert property (@(posedge core_clk) disable iff (!arst_n)
		rd_ack && legal_sel |-> rd_entry[1] == 8'h02 && rd_entry[2] == 8'h00)
		else $error("flag word wrong");

	chk_fixed_bytes: assert property (@(posedge core_clk) disable iff (!arst_n)
		rd_ack && fixed_kind |-> rd_entry[3] == 8'h64 && rd_entry[4] == 8'h64)
		else $error("fixed value bytes wrong");

	chk_reserved_zero: assert property (@(posedge core_clk) disable iff (!arst_n)
		rd_ack |-> rd_entry[11] == 8'h00) else $error("reserved byte not zero");

	chk_trim_range: assert property (@(posedge core_clk) disable iff (!arst_n)
		trim_valid |=> trim_value <= 8'd99 && (trim_value == $past(trim_pct)
		|| $past(trim_pct) > 8'd99)) else $error("trim percentage out of range");

	chk_temp_bytes: assert property (@(posedge core_clk) disable iff (!arst_n)
		rd_ack && rd_sel == ATTR_TEMP |-> rd_entry[3] == rd_entry[5]
		&& rd_entry[4] == rd_entry[7] && rd_entry[6] <= rd_entry[5])
		else $error("temperature bytes inconsistent");

	chk_count_saturate: assert property (@(posedge core_clk) disable iff (!arst_n)
		!restore_valid && $past(arst_n) |=> cnt_anchor >= $past(cnt_anchor))
		else $error("anchor count wrapped");

	chk_illegal_zero: assert property (@(posedge core_clk) disable iff (!arst_n)
		rd_ack && !legal_sel |-> rd_entry == '0) else $error("unknown entry not zero");

	chk_worst_fixed: assert property (@(posedge core_clk) disable iff (!arst_n)
		rd_ack && fixed_kind |-> rd_entry[4] == FIXED_VALUE)
		else $error("worst byte not fixed");

	chk_ecc_upper: assert property (@(posedge core_clk) disable iff (!arst_n)
		rd_ack && rd_sel == ATTR_ECC_CORR |-> rd_entry[10:9] == 16'h0000)
		else $error("ecc entry upper bytes not zero");

	chk_reads_entry: assert property (@(posedge core_clk) disable iff (!arst_n)
		rd_req.valid && rd_req.sel == ATTR_READS |=> rd_entry[0] == ID_READS
		&& rd_entry[10:5] == $past(cnt_reads)) else $error("read command entry wrong");

	chk_power_entry: assert property (@(posedge core_clk) disable iff (!arst_n)
		rd_req.valid && rd_req.sel == ATTR_POWER |=> rd_entry[0] == ID_POWER
		&& rd_entry[8:5] == $past(cnt_power) && rd_entry[10:9] == 16'h0000)
		else $error("power entry wrong");

	chk_wr_id: assert property (@(posedge core_clk) disable iff (!arst_n)
		rd_ack && rd_sel == ATTR_LBA_WR |-> rd_entry[0] == ID_LBA_WR)
		else $error("written entry id wrong");

	chk_rd_div: assert property (@(posedge core_clk) disable iff (!arst_n)
		rd_req.valid && rd_req.sel == ATTR_LBA_RD |=> rd_entry[0] == ID_LBA_RD
		&& rd_entry[10:5] == $past(cnt_lba_rd[63:16])) else $error("read entry not divided");

	chk_anchor_count: assert property (@(posedge core_clk) disable iff (!arst_n)
		anchor_rewrite_evt && !restore_valid && cnt_anchor != '1 |=>
		cnt_anchor == $past(cnt_anchor) + 32'h1) else $error("anchor rewrite not counted");

	chk_anchor_entry: assert property (@(posedge core_clk) disable iff (!arst_n)
		rd_req.valid && rd_req.sel == ATTR_ANCHOR |=> rd_entry[0] == ID_ANCHOR
		&& rd_entry[8:5] == $past(cnt_anchor) && rd_entry[10:9] == 16'h0000)
		else $error("anchor entry wrong");

	chk_trim_entry: assert property (@(posedge core_clk) disable iff (!arst_n)
		rd_req.valid && rd_req.sel == ATTR_TRIM |=> rd_entry[0] == ID_TRIM
		&& rd_entry[3] == $past(trim_value) && rd_entry[10:5] == 48'h0)
		else $error("trim entry wrong");

	chk_temp_entry: assert property (@(posedge core_clk) disable iff (!arst_n)
		rd_req.valid && rd_req.sel == ATTR_TEMP |=> rd_entry[0] == ID_TEMP
		&& rd_entry[3] == $past(temp_cur) && rd_entry[4] == $past(temp_max))
		else $error("temperature entry wrong");

	chk_lsb_first: assert property (@(posedge core_clk) disable iff (!arst_n)
		rd_req.valid && rd_req.sel == ATTR_UDMA_CRC |=>
		rd_entry[5] == $past(cnt_crc[7:0]) && rd_entry[8] == $past(cnt_crc[31:24]))
		else $error("count byte order wrong");

endmodule

/* hrb_sensor_model.sv */
// Behavioural temperature sensor answering the builder's sample requests
`timescale 1ns/1ns
module hrb_sensor_model (
	// Clock
	input  wire logic       core_clk,
	// Request from the builder
	input  wire logic       temp_req,
	// Bench controls
	input  wire logic [7:0] level,
	input  wire logic [3:0] delay,
	// Answer
	output logic            temp_ack,
	output logic [7:0]      temp_data
);
	// ----------------------------------------
	// Answer after a programmable delay
	// ----------------------------------------
	initial begin
		temp_ack = 1'b0;
		temp_data = 8'h5a;
		forever begin
			@(posedge core_clk);
			if (temp_req === 1'b1) begin
				repeat (delay) @(posedge core_clk);
				// Non-blocking so bench waits on the falling edge see a settled value
				@(negedge core_clk);
				temp_ack  <= 1'b1;
				temp_data <= level;
				@(negedge core_clk);
				temp_ack  <= 1'b0;
				// Data released: show the inverse, not a held value
				temp_data <= ~level;
			end
		end
	end
endmodule

/* hrb_attr_builder_tb.sv */
// Self-checking testbench for the health attribute record builder
`timescale 1ns/1ns
module hrb_attr_builder_tb;
	import hrb_pkg::*;
	localparam int TP = 20;
	logic         core_clk, arst_n, restore_valid, trim_valid, temp_req, temp_ack, rd_ack;
	logic         ecc_corr_evt, udma_crc_evt, flash_read_evt, anchor_rewrite_evt;
	hrb_lba_evt_t lba_wr, lba_rd;
	hrb_restore_t restore;
	logic [7:0]   trim_pct, temp_data, sens_level, trim, t_cur, t_min, t_max;
	logic [3:0]   sens_delay;
	hrb_rd_req_t  rd_req;
	hrb_attr_t    rd_sel;
	hrb_entry_t   rd_entry;
	logic [31:0]  seed;
	logic [63:0]  m [7];
	logic         t_seen;
	int           errors, n_checks, n;
	int           W [7] = '{32, 32, 48, 32, 64, 64, 32};
	logic [7:0]   ID [9] = '{8'hcc, 8'hc7, 8'he8, 8'h0c, 8'hf1, 8'hf2, 8'hd6, 8'hd7, 8'hc2};
	logic [7:0]   lv [3] = '{8'h32, 8'h1e, 8'h46};
	logic [7:0]   tv [5] = '{8'h00, 8'h63, 8'h64, 8'hff, 8'h2a};

	hrb_attr_builder #(.TEMP_PERIOD(TP)) i_hrb_attr_builder (.core_clk(core_clk),
		.arst_n(arst_n), .ecc_corr_evt(ecc_corr_evt), .udma_crc_evt(udma_crc_evt),
		.flash_read_evt(flash_read_evt), .anchor_rewrite_evt(anchor_rewrite_evt),
		.lba_wr(lba_wr), .lba_rd(lba_rd), .restore_valid(restore_valid), .restore(restore),
		.trim_valid(trim_valid), .trim_pct(trim_pct), .temp_req(temp_req),
		.temp_ack(temp_ack), .temp_data(temp_data), .rd_req(rd_req), .rd_ack(rd_ack),
		.rd_sel(rd_sel), .rd_entry(rd_entry));
	hrb_sensor_model i_hrb_sensor_model (.core_clk(core_clk), .temp_req(temp_req),
		.level(sens_level), .delay(sens_delay), .temp_ack(temp_ack), .temp_data(temp_data));

	// ----------------------------------------
	// Clock, temperature monitor, model helpers
	// ----------------------------------------
	initial begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end

	always @(posedge core_clk) begin
		if (arst_n === 1'b1 && temp_ack === 1'b1) begin
			t_min = (!t_seen || temp_data < t_min) ? temp_data : t_min;
			t_max = (!t_seen || temp_data > t_max) ? temp_data : t_max;
			t_cur = temp_data;
			t_seen = 1'b1;
		end
	end

	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction

	function automatic logic [63:0] sat(input logic [63:0] v, input logic [63:0] a, input int w);
		logic [64:0] s;
		logic [64:0] mx;
		s = {1'b0, v} + {1'b0, a};
		mx = (65'h1 << w) - 65'h1;
		return (s > mx) ? mx[63:0] : s[63:0];
	endfunction

	function automatic hrb_entry_t exp_entry(input logic [3:0] s);
		hrb_entry_t  e;
		logic [63:0] raw;
		e = '0;
		if (s > 4'h8) return e;
		e[0] = ID[s];
		e[1] = 8'h02;
		e[3] = 8'h64;
		e[4] = 8'h64;
		if (s == 4'h7) begin
			e[3] = trim;
			e[4] = trim;
		end else if (s == 4'h8) begin
			e[3] = t_cur;
			e[4] = t_max;
			e[5] = t_cur;
			e[6] = t_min;
			e[7] = t_max;
		end else begin
			raw = (s == 4'h4 || s == 4'h5) ? (m[s] >> 16) : m[s];
			for (int i = 0; i < 6; i++) e[5+i] = raw[8*i +: 8];
		end
		return e;
	endfunction

	// ----------------------------------------
	// Compare, drive and closing tasks
	// ----------------------------------------
	task automatic check_entry(input hrb_entry_t got, input hrb_entry_t exp);
		n_checks++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic complete_run();
		$display("checks=%0d errors=%0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask

	task automatic rd(input logic [3:0] s);
		hrb_entry_t e;
		e = exp_entry(s);
		rd_req.valid = 1'b1;
		rd_req.sel = hrb_attr_t'(s);
		@(negedge core_clk);
		rd_req.valid = 1'b0;
		check_val({31'h0, rd_ack}, 32'h1);
		check_val({28'h0, rd_sel}, {28'h0, s});
		check_entry(rd_entry, e);
		@(negedge core_clk);
		check_val({31'h0, rd_ack}, 32'h0);
	endtask

	task automatic events(input logic [5:0] f, input logic [15:0] cw, input logic [15:0] cr);
		ecc_corr_evt = f[0];
		udma_crc_evt = f[1];
		flash_read_evt = f[2];
		anchor_rewrite_evt = f[3];
		lba_wr = '{valid: f[4], count: cw};
		lba_rd = '{valid: f[5], count: cr};
		if (f[0]) m[0] = sat(m[0], 64'h1, W[0]);
		if (f[1]) m[1] = sat(m[1], 64'h1, W[1]);
		if (f[2]) m[2] = sat(m[2], 64'h1, W[2]);
		if (f[3]) m[6] = sat(m[6], 64'h1, W[6]);
		if (f[4]) m[4] = sat(m[4], {48'h0, cw}, 64);
		if (f[5]) m[5] = sat(m[5], {48'h0, cr}, 64);
		@(negedge core_clk);
	endtask

	task automatic wait_for(input bit ack_sel, output int k);
		k = 0;
		do begin
			@(negedge core_clk);
			k++;
		end while (((ack_sel ? temp_ack : temp_req) !== 1'b1) && k < 200);
		if (k >= 200) begin
			errors++;
			complete_run();
		end
	endtask

	task automatic do_reset(input int cycles);
		arst_n = 1'b0;
		foreach (m[i]) m[i] = 64'h0;
		{trim, t_cur, t_min, t_max, t_seen} = '0;
		repeat (cycles) @(negedge core_clk);
		check_val({31'h0, rd_ack}, 32'h0);
		check_entry(rd_entry, '0);
		arst_n = 1'b1;
		m[3] = 64'h1;
		@(negedge core_clk);
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		{errors, n_checks} = '0;
		seed = 32'h2cc6af65;
		{ecc_corr_evt, udma_crc_evt, flash_read_evt, anchor_rewrite_evt} = '0;
		{lba_wr, lba_rd, restore, restore_valid, trim_valid, trim_pct, rd_req} = '0;
		sens_level = 8'h19;
		sens_delay = 4'h2;
		do_reset(6);
		rd(4'h3);
		repeat (80) begin
			seed = lfsr(seed);
			events(seed[5:0], seed[31:16], seed[15:0]);
		end
		events(6'h0, 16'h0, 16'h0);
		for (int s = 0; s < 16; s++) rd(s[3:0]);
		foreach (tv[k]) begin
			trim_valid = 1'b1;
			trim_pct = tv[k];
			trim = (tv[k] > 8'd99) ? 8'd99 : tv[k];
			@(negedge core_clk);
			trim_valid = 1'b0;
			rd(4'h7);
		end
		restore = '{power: 32'h1234_5678, ecc_corr: 32'hffff_ffff, udma_crc: 32'hffff_fffe,
			anchor: 32'hffff_fffe, reads: 48'hffff_ffff_fffe,
			lba_wr: 64'hffff_ffff_fffe_8000, lba_rd: 64'h0000_0001_2345_ffff};
		restore_valid = 1'b1;
		{m[3], m[0], m[1], m[6], m[2]} = {32'h0, restore.power, 32'h0, restore.ecc_corr,
			32'h0, restore.udma_crc, 32'h0, restore.anchor, 16'h0, restore.reads};
		m[4] = restore.lba_wr;
		m[5] = restore.lba_rd;
		@(negedge core_clk);
		restore_valid = 1'b0;
		repeat (3) events(6'h3f, 16'hffff, 16'h0001);
		events(6'h0, 16'h0, 16'h0);
		for (int s = 0; s < 7; s++) rd(s[3:0]);
		foreach (lv[k]) begin
			sens_level = lv[k];
			sens_delay = 4'(5 * k + 1);
			wait_for(1'b0, n);
			wait_for(1'b0, n);
			check_val(n, TP);
			wait_for(1'b1, n);
			@(negedge core_clk);
			rd(4'h8);
		end
		do_reset(2);
		rd(4'h3);
		rd(4'h8);
		complete_run();
	end
endmodule
